//--- hdl/cec_core_ctrl.sv
/*
 core enhancement control: clock halving stage with double speed bypass,
 dual data pointers, framing error detection with shared serial control
 bit, power control register.
 assumes core_clk is the crystal clock, the receiver gives same-clock
 strobes, and cold_start is high from power-on logic on the same clock.
*/
`timescale 1ns/1ns
// How it works
// R1 - double speed: machine cycle takes six crystal periods
// R2 - halving stage before phase generator, software can bypass it
// R3 - standard mode clocks core and peripherals at half crystal rate
// R4 - speed change is taken only on a rising edge of the halved clock
// R5 - two independent 16-bit data pointers, one select bit picks the used one
// R6 - select bit is auxiliary bit 0; zero picks first, one second
// R7 - incrementing the auxiliary register toggles the select bit
// R8 - select bit resets to zero, other auxiliary bits undefined
// R9 - software never sets reserved bits, their reads are meaningless
// R10 - serial asynchronous modes 1, 2, 3 run full duplex
// R11 - framing check in async modes only when access select bit is set
// R12 - when enabled, a bad stop bit sets the framing error flag
// R13 - framing error stays set until software clear or reset
// R14 - when enabled, receive done rises at stop bit, not last data bit
// R15 - power bit 6 makes shared serial bit reach mode bit or error flag
// R16 - power-off flag set at power-up, software may set or clear it
// R17 - power-off flag is one only after cold start, warm reset keeps it
// R18 - power bit 1 enters power down, any reset clears it
// R19 - power bit 0 enters idle, interrupt or reset clears it
// R20 - power bits 3, 2 and auxiliary bit 3 are plain user flags
// R21 - power register resets to 00x1 0000 cold, bit 5 undefined
// R22 - auxiliary bit 2 always reads zero
// R23 - double speed select arrives as an input from elsewhere
// R24 - power bit 7 drives baud doubling output to the serial port
module cec_core_ctrl (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cold_start,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_inc,
   output logic [7:0] reg_rdata,
   input wire logic double_speed_select,
   output logic standard_speed,
   output logic phase_enable,
   output logic machine_cycle_end,
   input wire logic data_pointer_load,
   input wire logic [15:0] data_pointer_load_value,
   input wire logic data_pointer_inc,
   output logic [15:0] data_pointer,
   output logic [15:0] data_pointer_first,
   output logic [15:0] data_pointer_second,
   input wire logic serial_mode_bit_one,
   input wire logic rx_last_data_strobe,
   input wire logic rx_stop_strobe,
   input wire logic rx_stop_value,
   output logic serial_mode_bit_zero,
   output logic framing_error_flag,
   output logic receive_done_set,
   output logic baud_doubler,
   input wire logic interrupt_taken,
   output logic power_down_mode,
   output logic idle_mode
);
   import cec_pkg::*;

   // double speed select synchroniser; the source is another block's flop
   // but may sit on a different domain, so it is treated as foreign
   logic ds_meta_q;
   logic ds_sync_q;
   logic half_q;
   logic half_d;
   logic half_rise;
   logic double_q;
   logic double_d;
   logic phase_en_d;
   logic phase_en_q;
   logic [2:0] phase_cnt_q;
   logic [2:0] phase_cnt_d;
   logic [2:0] phase_last;
   logic mc_end_d;
   logic mc_end_q;
   logic std_d;
   logic std_q;

   // register bus decode
   logic sel_psc;
   logic sel_apc;
   logic sel_scn;
   logic wr_psc;
   logic wr_apc;
   logic wr_scn;
   logic inc_apc;

   // register contents
   logic baud_q;
   logic fe_sel_q;
   logic pof_q;
   logic gf1_q;
   logic gf0_q;
   logic pd_q;
   logic idl_q;
   logic gf3_q;
   logic dps_q;
   logic dps_d;
   logic sm0_q;
   logic fe_q;
   logic fe_d;
   logic [7:0] psc_value;
   logic [7:0] apc_value;
   logic [7:0] scn_value;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic [7:0] sel_value;
   logic baud_d;
   logic fe_sel_d;
   logic pof_d;
   logic pof_rst;
   logic gf1_d;
   logic gf0_d;
   logic pd_d;
   logic idl_d;
   logic gf3_d;
   logic sm0_d;

   // data pointers
   logic [15:0] dp_q [2];
   logic [15:0] dp_d [2];
   logic [15:0] dp_out_q;
   logic [15:0] dp_sel_d;

   // serial framing
   logic async_mode;
   logic frame_check_en;
   logic frame_bad;
   logic rx_done_d;
   logic rx_done_q;

   // halving stage: half_q rises every second crystal cycle
   assign half_d = ~half_q;
   assign half_rise = ~half_q;
   // speed mode is latched only where the halved clock rises
   assign double_d = half_rise ? ds_sync_q : double_q; // R4 R23
   // bypass feeds every crystal cycle, else one in two
   assign phase_en_d = double_d | half_rise; // R2 R3
   // standard mode counts six halved periods, i.e. twelve crystal ones
   assign phase_last = PHASE_COUNT_LAST;
   assign phase_cnt_d = ~phase_en_d ? phase_cnt_q :
                        (phase_cnt_q == phase_last) ? 3'h0 :
                        3'(phase_cnt_q + 3'h1); // R1
   assign mc_end_d = phase_en_d & (phase_cnt_q == phase_last); // R1
   // flopped so the output carries no gate after the register
   assign std_d = ~double_d; // R3

   // two flops before anything reads the double speed select
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ds_meta_q <= 1'b0;
         ds_sync_q <= 1'b0;
      end else begin
         ds_meta_q <= double_speed_select;
         ds_sync_q <= ds_meta_q; // R23
      end
   end

   // counter runs on through a speed change; the cycle in progress
   // just finishes at the new rate
   always_ff @(posedge core_clk) begin
      if (rst) begin
         half_q <= 1'b0;
         double_q <= 1'b0;
         std_q <= 1'b1;
         phase_en_q <= 1'b0;
         phase_cnt_q <= 3'h0;
         mc_end_q <= 1'b0;
      end else begin
         half_q <= half_d;
         double_q <= double_d;
         std_q <= std_d;
         phase_en_q <= phase_en_d;
         phase_cnt_q <= phase_cnt_d;
         mc_end_q <= mc_end_d;
      end
   end

   // address decode
   assign sel_psc = reg_addr == POWER_AND_SERIAL_CONTROL_OFFSET;
   assign sel_apc = reg_addr == AUXILIARY_POINTER_CONTROL_OFFSET;
   assign sel_scn = reg_addr == SERIAL_CONTROL_OFFSET;
   assign wr_psc = reg_wr & sel_psc;
   assign wr_apc = reg_wr & sel_apc;
   assign wr_scn = reg_wr & sel_scn;
   // increment is a read-modify-write of the select bit only
   assign inc_apc = reg_inc & sel_apc;

   // toggle, never force, on increment
   assign dps_d = inc_apc ? ~dps_q :
                  wr_apc ? reg_wdata[APC_POINTER_SELECT_POS] : dps_q; // R6 R7

   // framing check
   assign async_mode = sm0_q | serial_mode_bit_one; // R10
   assign frame_check_en = fe_sel_q & async_mode; // R11
   assign frame_bad = frame_check_en & rx_stop_strobe & ~rx_stop_value; // R12
   // hardware set beats a software clear in the same cycle
   assign fe_d = frame_bad |
                 ((wr_scn & fe_sel_q) ? reg_wdata[SCN_SHARED_POS] : fe_q); // R13
   assign rx_done_d = frame_check_en ? rx_stop_strobe :
                      rx_last_data_strobe; // R14

   // read views; reserved bits read zero
   assign psc_value = {baud_q, fe_sel_q, 1'b0, pof_q,
                       gf1_q, gf0_q, pd_q, idl_q}; // R21
   assign apc_value = {4'h0, gf3_q, 1'b0, 1'b0, dps_q}; // R22
   assign scn_value = {(fe_sel_q ? fe_q : sm0_q), 7'h00}; // R15
   assign sel_value = sel_psc ? psc_value :
                      sel_apc ? apc_value :
                      sel_scn ? scn_value : 8'h00;
   // idle bus reads zero so a stale value is never taken for data
   assign rdata_d = reg_rd ? sel_value : 8'h00;

   // power register next values, one named wire per field
   assign baud_d = wr_psc ? reg_wdata[PSC_BAUD_DOUBLER_POS] :
                   baud_q; // R24
   assign fe_sel_d = wr_psc ? reg_wdata[PSC_FRAME_ERR_SEL_POS] :
                     fe_sel_q; // R15
   assign pof_d = wr_psc ? reg_wdata[PSC_POWER_OFF_POS] : pof_q; // R16
   assign gf1_d = wr_psc ? reg_wdata[PSC_USER_FLAG_ONE_POS] :
                  gf1_q; // R20
   assign gf0_d = wr_psc ? reg_wdata[PSC_USER_FLAG_ZERO_POS] :
                  gf0_q; // R20
   assign pd_d = wr_psc ? reg_wdata[PSC_POWER_DOWN_POS] : pd_q; // R18
   // interrupt wakes from idle even if software writes the bit
   assign idl_d = interrupt_taken ? 1'b0 :
                  wr_psc ? reg_wdata[PSC_SLEEP_REQ_POS] : idl_q; // R19
   // a cold start sets the flag, a warm reset leaves it alone
   assign pof_rst = cold_start ? PSC_RESET_COLD[PSC_POWER_OFF_POS] :
                    pof_q; // R16 R17
   assign gf3_d = wr_apc ? reg_wdata[APC_USER_FLAG_THREE_POS] :
                  gf3_q; // R20
   // shared location reaches the mode bit only while select is clear
   assign sm0_d = (wr_scn & ~fe_sel_q) ? reg_wdata[SCN_SHARED_POS] :
                  sm0_q; // R15

   // power register; only the power-off flag looks at the reset kind
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pof_q <= pof_rst; // R17
         baud_q <= PSC_RESET_WARM[PSC_BAUD_DOUBLER_POS];
         fe_sel_q <= PSC_RESET_WARM[PSC_FRAME_ERR_SEL_POS];
         gf1_q <= PSC_RESET_WARM[PSC_USER_FLAG_ONE_POS];
         gf0_q <= PSC_RESET_WARM[PSC_USER_FLAG_ZERO_POS];
         pd_q <= PSC_RESET_WARM[PSC_POWER_DOWN_POS]; // R18
         idl_q <= PSC_RESET_WARM[PSC_SLEEP_REQ_POS]; // R19
      end else begin
         pof_q <= pof_d;
         baud_q <= baud_d;
         fe_sel_q <= fe_sel_d;
         gf1_q <= gf1_d;
         gf0_q <= gf0_d;
         pd_q <= pd_d;
         idl_q <= idl_d;
      end
   end

   // auxiliary register: select bit and user flag
   always_ff @(posedge core_clk) begin
      if (rst) begin
         gf3_q <= APC_RESET[APC_USER_FLAG_THREE_POS];
         dps_q <= APC_RESET[APC_POINTER_SELECT_POS]; // R8
      end else begin
         gf3_q <= gf3_d;
         dps_q <= dps_d;
      end
   end

   // shared serial location and receive strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sm0_q <= 1'b0;
         fe_q <= 1'b0;
         rx_done_q <= 1'b0;
      end else begin
         sm0_q <= sm0_d;
         fe_q <= fe_d;
         rx_done_q <= rx_done_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // pointer update goes to the one the select bit picks
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_dp
         logic hit;
         logic [15:0] bumped;
         assign hit = dps_q == 1'(gi); // R5 R6
         // pointer wraps at the top of the 16-bit space
         assign bumped = 16'(dp_q[gi] + 16'h0001);
         // load wins over increment if both arrive together
         assign dp_d[gi] = ~hit ? dp_q[gi] :
                           data_pointer_load ? data_pointer_load_value :
                           data_pointer_inc ? bumped : dp_q[gi];
         always_ff @(posedge core_clk) begin
            if (rst) begin
               dp_q[gi] <= DATA_POINTER_RESET;
            end else begin
               dp_q[gi] <= dp_d[gi]; // R5
            end
         end
      end
   endgenerate

   assign dp_sel_d = dps_d ? dp_d[1] : dp_d[0]; // R6

   // selected view lands together with the pointer it copies
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dp_out_q <= DATA_POINTER_RESET;
      end else begin
         dp_out_q <= dp_sel_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign standard_speed = std_q;
   assign phase_enable = phase_en_q;
   assign machine_cycle_end = mc_end_q;
   assign data_pointer = dp_out_q;
   assign data_pointer_first = dp_q[0];
   assign data_pointer_second = dp_q[1];
   assign serial_mode_bit_zero = sm0_q;
   assign framing_error_flag = fe_q;
   assign receive_done_set = rx_done_q;
   assign baud_doubler = baud_q;
   assign power_down_mode = pd_q;
   assign idle_mode = idl_q;
endmodule

//--- hdl/cec_pkg.sv
/*
 package of core enhancement control: register offsets, field positions,
 reset values and clock timing counts.
 assumes an 8-bit special register address space and 8-bit data.
*/
package cec_pkg;
   // register offsets
   localparam logic [7:0] POWER_AND_SERIAL_CONTROL_OFFSET = 8'h87;
   localparam logic [7:0] AUXILIARY_POINTER_CONTROL_OFFSET = 8'ha2;
   localparam logic [7:0] SERIAL_CONTROL_OFFSET = 8'h98;

   // power_and_serial_control fields
   localparam int PSC_BAUD_DOUBLER_POS = 7;
   localparam int PSC_FRAME_ERR_SEL_POS = 6;
   localparam int PSC_POWER_OFF_POS = 4;
   localparam int PSC_USER_FLAG_ONE_POS = 3;
   localparam int PSC_USER_FLAG_ZERO_POS = 2;
   localparam int PSC_POWER_DOWN_POS = 1;
   localparam int PSC_SLEEP_REQ_POS = 0;

   // auxiliary_pointer_control fields
   localparam int APC_USER_FLAG_THREE_POS = 3;
   localparam int APC_POINTER_SELECT_POS = 0;

   // serial_control shared location
   localparam int SCN_SHARED_POS = 7;

   // reset values
   localparam logic [7:0] PSC_RESET_COLD = 8'h10;
   localparam logic [7:0] PSC_RESET_WARM = 8'h00;
   localparam logic [7:0] APC_RESET = 8'h00;
   localparam logic [15:0] DATA_POINTER_RESET = 16'h0000;

   // clock timing
   localparam int CLOCK_HALVING = 2;
   localparam logic [2:0] PHASES_PER_MACHINE_CYCLE = 3'h6;
   localparam logic [2:0] PHASE_COUNT_LAST = 3'(PHASES_PER_MACHINE_CYCLE - 1);
endpackage

//--- dv/cec_core_ctrl_monitor.sv
/*
 assertions on the core enhancement control ports.
 assumes one clock domain and a synchronous active high reset.
*/
`timescale 1ns/1ns
module cec_core_ctrl_monitor (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic standard_speed,
   input wire logic phase_enable,
   input wire logic machine_cycle_end,
   input wire logic rx_last_data_strobe,
   input wire logic rx_stop_strobe,
   input wire logic framing_error_flag,
   input wire logic receive_done_set,
   input wire logic baud_doubler,
   input wire logic interrupt_taken,
   input wire logic power_down_mode,
   input wire logic idle_mode
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // depth 3 leaves room for the speed change to settle
   a_dbl_phase:
      assert property (!standard_speed && !$past(standard_speed, 3)
         |-> phase_enable) else $error("double speed phase missing");
   a_std_alt:
      assert property (phase_enable && standard_speed ##1 standard_speed
         |-> !phase_enable) else $error("standard phase too fast");
   a_mce_six:
      assert property (machine_cycle_end && !standard_speed |=>
         (!machine_cycle_end) [*5] ##1 (machine_cycle_end || standard_speed))
         else $error("double speed machine cycle not six");
   a_fe_cause:
      assert property ($rose(framing_error_flag) |-> $past(rx_stop_strobe)
         || $past(reg_wr)) else $error("framing flag set without cause");
   a_fe_sticky:
      assert property ($fell(framing_error_flag) |-> $past(reg_wr))
         else $error("framing flag dropped without a write");
   a_done_cause:
      assert property (receive_done_set |-> $past(rx_stop_strobe)
         || $past(rx_last_data_strobe)) else $error("receive done uncaused");
   a_idle_clear:
      assert property (interrupt_taken |=> !idle_mode)
         else $error("idle kept after interrupt");
   a_psc_bits:
      assert property (reg_wr && reg_addr == 8'h87 |=> baud_doubler ==
         $past(reg_wdata[7]) && power_down_mode == $past(reg_wdata[1]))
         else $error("power register outputs wrong");
   c_fe_set: cover property ($rose(framing_error_flag));
   c_dbl_mce: cover property (machine_cycle_end && !standard_speed);
   c_idle_wake: cover property (idle_mode ##1 !idle_mode);
endmodule

bind cec_core_ctrl cec_core_ctrl_monitor u_mon (
   .core_clk(core_clk),
   .rst(rst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .standard_speed(standard_speed),
   .phase_enable(phase_enable),
   .machine_cycle_end(machine_cycle_end),
   .rx_last_data_strobe(rx_last_data_strobe),
   .rx_stop_strobe(rx_stop_strobe),
   .framing_error_flag(framing_error_flag),
   .receive_done_set(receive_done_set),
   .baud_doubler(baud_doubler),
   .interrupt_taken(interrupt_taken),
   .power_down_mode(power_down_mode),
   .idle_mode(idle_mode)
);

//--- dv/test_cec_core_ctrl.sv
/*
 self-checking bench of core enhancement control.
 assumes the bench drives every port itself; no far-side model.
*/
`timescale 1ns/1ns
module test_cec_core_ctrl;
   import cec_pkg::*;
   logic core_clk = 0, rst = 1, cold_start = 1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_wr = 0, reg_rd = 0, reg_inc = 0, double_speed_select = 0;
   logic standard_speed, phase_enable, machine_cycle_end;
   logic data_pointer_load = 0, data_pointer_inc = 0;
   logic [15:0] data_pointer_load_value = 16'h0000;
   logic [15:0] data_pointer, data_pointer_first, data_pointer_second;
   logic serial_mode_bit_one = 1, rx_last_data_strobe = 0;
   logic rx_stop_strobe = 0, rx_stop_value = 1, interrupt_taken = 0;
   logic serial_mode_bit_zero, framing_error_flag, receive_done_set;
   logic baud_doubler, power_down_mode, idle_mode;
   int n_errors = 0, checks = 0;
   cec_core_ctrl u_dut (
      .core_clk(core_clk),
      .rst(rst),
      .cold_start(cold_start),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_inc(reg_inc),
      .reg_rdata(reg_rdata),
      .double_speed_select(double_speed_select),
      .standard_speed(standard_speed),
      .phase_enable(phase_enable),
      .machine_cycle_end(machine_cycle_end),
      .data_pointer_load(data_pointer_load),
      .data_pointer_load_value(data_pointer_load_value),
      .data_pointer_inc(data_pointer_inc),
      .data_pointer(data_pointer),
      .data_pointer_first(data_pointer_first),
      .data_pointer_second(data_pointer_second),
      .serial_mode_bit_one(serial_mode_bit_one),
      .rx_last_data_strobe(rx_last_data_strobe),
      .rx_stop_strobe(rx_stop_strobe),
      .rx_stop_value(rx_stop_value),
      .serial_mode_bit_zero(serial_mode_bit_zero),
      .framing_error_flag(framing_error_flag),
      .receive_done_set(receive_done_set),
      .baud_doubler(baud_doubler),
      .interrupt_taken(interrupt_taken),
      .power_down_mode(power_down_mode),
      .idle_mode(idle_mode)
   );
   initial forever #5 core_clk = ~core_clk;
   task test_done;
      $display("checks=%0d errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] e);
      checks++;
      if (seen !== e) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, e);
      end
   endtask
   task tick;
      @(posedge core_clk);
   endtask
   task step;
      @(posedge core_clk);
      #1;
   endtask
   task do_reset(input logic cold);
      tick;
      rst <= 1;
      cold_start <= cold;
      repeat (6) tick;
      rst <= 0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      tick;
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      tick;
      reg_wr <= 0;
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      tick;
      reg_rd <= 1;
      reg_addr <= a;
      tick;
      reg_rd <= 0;
      #1 chk(reg_rdata, e);
   endtask
   // k picks one strobe: 0 inc, 1 load, 2 ptr inc, 3 stop, 4 last, 5 irq
   task fire(input int k, input logic [15:0] v);
      tick;
      data_pointer_load_value <= v;
      rx_stop_value <= v[0];
      {reg_inc, data_pointer_load, data_pointer_inc, rx_stop_strobe,
         rx_last_data_strobe, interrupt_taken} <= 6'h20 >> k;
      tick;
      {reg_inc, data_pointer_load, data_pointer_inc, rx_stop_strobe,
         rx_last_data_strobe, interrupt_taken} <= 6'h00;
      #1;
   endtask
   // first wait aligns to a machine cycle end, then the span is counted
   task gap(input logic [15:0] e);
      int n;
      for (int i = 0; i < 2; i++) begin
         n = 0;
         do begin
            step;
            n++;
         end while (machine_cycle_end !== 1'b1 && n < 40);
      end
      chk(n[15:0], e);
   endtask
   task s_power;
      rd(8'h87, PSC_RESET_COLD);
      wr(8'h87, 8'hdf);
      chk({baud_doubler, power_down_mode, idle_mode}, 16'h0007);
      rd(8'h87, 8'hdf);
      fire(5, 16'h0000);
      chk(idle_mode, 16'h0000);
      rd(8'h87, 8'hde);
      do_reset(0);
      rd(8'h87, 8'h10);
      wr(8'h87, 8'h00);
      do_reset(0);
      rd(8'h87, PSC_RESET_WARM);
      do_reset(1);
      rd(8'h87, PSC_RESET_COLD);
      rd(8'h55, 8'h00);
      wr(8'ha2, 8'h0d);
      rd(8'ha2, 8'h09);
   endtask
   task s_pointer;
      do_reset(0);
      rd(8'ha2, 8'h00);
      wr(8'ha2, 8'h00);
      fire(1, 16'h1234);
      step;
      chk(data_pointer, 16'h1234);
      fire(0, 16'h0000);
      rd(8'ha2, 8'h01);
      fire(1, 16'habcd);
      fire(2, 16'h0000);
      step;
      chk(data_pointer, 16'habce);
      chk(data_pointer_first, 16'h1234);
      chk(data_pointer_second, 16'habce);
      fire(0, 16'h0000);
      step;
      chk(data_pointer, 16'h1234);
   endtask
   task s_frame;
      wr(8'h87, 8'h40);
      fire(3, 16'h0000);
      chk({framing_error_flag, receive_done_set}, 16'h0003);
      fire(3, 16'h0001);
      chk(framing_error_flag, 16'h0001);
      rd(8'h98, 8'h80);
      wr(8'h98, 8'h00);
      chk(framing_error_flag, 16'h0000);
      fire(4, 16'h0000);
      chk(receive_done_set, 16'h0000);
      wr(8'h87, 8'h00);
      wr(8'h98, 8'h80);
      chk({serial_mode_bit_zero, framing_error_flag}, 16'h0002);
      rd(8'h98, 8'h80);
      fire(3, 16'h0000);
      chk({framing_error_flag, receive_done_set}, 16'h0000);
      fire(4, 16'h0000);
      chk(receive_done_set, 16'h0001);
      wr(8'h98, 8'h00);
      wr(8'h87, 8'h40);
      tick;
      serial_mode_bit_one <= 0;
      fire(3, 16'h0000);
      chk({framing_error_flag, receive_done_set}, 16'h0000);
      tick;
      serial_mode_bit_one <= 1;
   endtask
   task s_speed;
      logic p;
      tick;
      double_speed_select <= 1;
      repeat (8) step;
      chk(standard_speed, 16'h0000);
      chk(phase_enable, 16'h0001);
      gap(16'h0006);
      tick;
      double_speed_select <= 0;
      repeat (8) step;
      chk(standard_speed, 16'h0001);
      p = phase_enable;
      step;
      chk(phase_enable, !p);
      gap(16'h000c);
   endtask
   initial begin
      #100000;
      n_errors++;
      test_done;
   end
   initial begin
      do_reset(1);
      s_power;
      s_pointer;
      s_frame;
      s_speed;
      test_done;
   end
endmodule
